// ==== design/ipl_top.sv ====
// Injector pulse scheduler, low-side PWM and module presence probe
`timescale 1ns/100ps
module ipl_top (
  input wire logic I_CORE_CLK, // 40 MHz core clock
  input wire logic I_SYS_RST, // Synchronous reset, active high
  input wire ipl_pkg::ipl_engine_sync_bundle_t I_SYNC, // Position tracker bundle
  input wire ipl_pkg::ipl_injector_control_group_t [3:0] I_INJ_CTRL, // Injector controls
  input wire ipl_pkg::ipl_lowside_control_group_t [3:0] I_LS_CTRL, // Low-side controls
  input wire logic [3:0] I_INJ_OPEN_SENSE, // Injector open-load sense
  input wire logic [3:0] I_INJ_SHORT_SENSE, // Injector short sense
  input wire logic [3:0] I_LS_OPEN_SENSE, // Low-side open-load sense
  input wire logic [3:0] I_LS_SHORT_SENSE, // Low-side short sense
  input wire logic I_MODULE_ID_LINE, // Identification line level
  output ipl_pkg::ipl_injector_status_group_t [3:0] O_INJ_STATUS, // Injector flags
  output ipl_pkg::ipl_lowside_status_group_t [3:0] O_LS_STATUS, // Low-side flags
  output logic [3:0] O_INJ_DRIVE, // Injector command
  output logic [3:0] O_INJ_PEAK, // High: peak threshold, low: hold
  output logic [3:0] O_LS_DRIVE, // Low-side switch closed
  output logic O_MODULE_DETECTED, // Module powered and fitted
  output logic O_MODULE_ID_LINE_OE_N, // Identification line enable, low drives
  output logic O_MODULE_ID_LINE_VALUE // Identification line data
);

  localparam int NCH = ipl_pkg::NCH;
  localparam int LEN_W = ipl_pkg::LEN_W;
  localparam int LS_W = ipl_pkg::LS_W;
  localparam int PK_W = ipl_pkg::PEAK_CNT_W;

  // 2 MHz tick derived from the core clock
  logic [ipl_pkg::TICK_CNT_W-1:0] tick_cnt;
  logic tick;
  logic [ipl_pkg::TICK_CNT_W-1:0] next_tick_cnt;
  assign tick = (tick_cnt == ipl_pkg::TICK_CNT_W'(ipl_pkg::TICK_DIV - 1));
  assign next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // Injector channel state
  logic [NCH-1:0] inj_active, inj_armed, fire_prev, end_flag, inj_short, inj_open;
  logic [NCH-1:0] inj_peak_on;
  logic [LEN_W-1:0] inj_len [NCH];
  logic [PK_W-1:0] inj_peak [NCH];
  logic [NCH-1:0] next_active, next_armed, next_end_flag, next_inj_short, next_peak_on;
  logic [LEN_W-1:0] next_len [NCH];
  logic [PK_W-1:0] next_peak [NCH];

  // Angle match; a stale position from an unsynced tracker never counts
  function automatic logic angle_hit(input ipl_pkg::ipl_engine_sync_bundle_t s,
                                     input logic [ipl_pkg::POS_W-1:0] a);
    return s.sync_valid && (s.crank_tick_position == a);
  endfunction : angle_hit

  // Start, cut-off and fault decisions per injector channel
  always_comb begin
    ipl_pkg::ipl_injector_control_group_t c;
    logic at_start, at_end, start_norm, start_imm, start, kill;
    logic [LEN_W-1:0] len_req;
    c = '0;
    at_start = 1'b0;
    at_end = 1'b0;
    start_norm = 1'b0;
    start_imm = 1'b0;
    start = 1'b0;
    kill = 1'b0;
    len_req = '0;
    for (int i = 0; i < NCH; i++) begin
      c = I_INJ_CTRL[i];
      // Angle matches only count with a valid tracker bundle
      at_start = angle_hit(I_SYNC, c.pulse_start_angle);
      at_end = angle_hit(I_SYNC, c.cycle_end_angle);
      len_req = c.pulse_length[LEN_W-1:0];
      // Short sets win over a clear in the same cycle
      next_inj_short[i] = I_INJ_SHORT_SENSE[i] | (inj_short[i] & ~c.injector_fault_clear);
      start_norm = !c.fuel_immediate_mode && inj_armed[i] && at_start;
      start_imm = c.fuel_immediate_mode && c.fuel_fire_now && !fire_prev[i];
      start = c.fuel_channel_enable && !next_inj_short[i] && (start_norm || start_imm)
              && (len_req != '0);
      kill = at_end || !c.fuel_channel_enable || next_inj_short[i];
      next_active[i] = inj_active[i];
      next_len[i] = inj_len[i];
      next_peak[i] = inj_peak[i];
      if (kill) begin
        next_active[i] = 1'b0;
        next_len[i] = '0;
        next_peak[i] = '0;
      end else if (start) begin
        next_active[i] = 1'b1;
        next_len[i] = len_req;
        next_peak[i] = PK_W'(c.peak_time) * PK_W'(ipl_pkg::PEAK_SCALE);
      end else if (inj_active[i]) begin
        next_len[i] = inj_len[i] - 1'b1;
        next_active[i] = (inj_len[i] > LEN_W'(1));
        if (tick && inj_peak[i] != '0) begin
          next_peak[i] = inj_peak[i] - 1'b1;
        end
      end
      // Rearm at cycle end; a normal-mode start uses up the arm
      next_armed[i] = at_end ? 1'b1 : (start && start_norm) ? 1'b0 : inj_armed[i];
      next_end_flag[i] = at_end | (end_flag[i] & ~c.cycle_end_flag_clear);
      next_peak_on[i] = next_active[i] && (next_peak[i] != '0);
    end
  end

  // Injector registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      inj_active <= '0;
      inj_armed <= '1;
      fire_prev <= '0;
      end_flag <= '0;
      inj_short <= '0;
      inj_open <= '0;
      inj_peak_on <= '0;
      for (int i = 0; i < NCH; i++) begin
        inj_len[i] <= '0;
        inj_peak[i] <= '0;
      end
    end else begin
      inj_active <= next_active;
      inj_armed <= next_armed;
      end_flag <= next_end_flag;
      inj_short <= next_inj_short;
      inj_open <= I_INJ_OPEN_SENSE;
      inj_peak_on <= next_peak_on;
      for (int i = 0; i < NCH; i++) begin
        fire_prev[i] <= I_INJ_CTRL[i].fuel_fire_now;
        inj_len[i] <= next_len[i];
        inj_peak[i] <= next_peak[i];
      end
    end
  end

  // Low-side PWM channels
  logic [LS_W-1:0] ls_cnt [NCH];
  logic [LS_W-1:0] next_ls_cnt [NCH];
  logic [NCH-1:0] ls_short, ls_open, ls_drive;
  logic [NCH-1:0] next_ls_short, next_ls_drive;

  // Period counter and switch decision; wrap above 20 bits is by truncation
  always_comb begin
    logic [LS_W-1:0] per, on;
    logic run;
    per = '0;
    on = '0;
    run = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      per = I_LS_CTRL[i].lowside_period[LS_W-1:0];
      on = I_LS_CTRL[i].lowside_on_time[LS_W-1:0];
      next_ls_short[i] = I_LS_SHORT_SENSE[i] | (ls_short[i] & ~I_LS_CTRL[i].lowside_fault_clear);
      run = I_LS_CTRL[i].lowside_pwm_enable && !next_ls_short[i];
      next_ls_cnt[i] = ls_cnt[i];
      if (!run) begin
        next_ls_cnt[i] = '0;
      end else if (tick) begin
        next_ls_cnt[i] = (ls_cnt[i] + 1'b1 >= per) ? '0 : ls_cnt[i] + 1'b1;
      end
      // Counter restarts at zero each period, so low counts mean closed
      next_ls_drive[i] = run && (on != '0) && ((on >= per) || (next_ls_cnt[i] < on));
    end
  end

  // Low-side registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      ls_short <= '0;
      ls_open <= '0;
      ls_drive <= '0;
      for (int i = 0; i < NCH; i++) begin
        ls_cnt[i] <= '0;
      end
    end else begin
      ls_short <= next_ls_short;
      ls_open <= I_LS_OPEN_SENSE;
      ls_drive <= next_ls_drive;
      for (int i = 0; i < NCH; i++) begin
        ls_cnt[i] <= next_ls_cnt[i];
      end
    end
  end

  // Presence probe: pull the line low, release, expect the module pull-up
  ipl_pkg::ipl_id_state_t id_state, next_id_state;
  logic [ipl_pkg::ID_CNT_W-1:0] id_cnt, next_id_cnt;
  logic id_phase_end;
  assign id_phase_end = (id_cnt == ipl_pkg::ID_CNT_W'(ipl_pkg::ID_PHASE_CYCLES - 1));

  always_comb begin
    next_id_state = id_state;
    next_id_cnt = id_phase_end ? '0 : id_cnt + 1'b1;
    case (id_state)
      ipl_pkg::IPL_ID_DRIVE: begin
        if (id_phase_end) begin
          next_id_state = I_MODULE_ID_LINE ? ipl_pkg::IPL_ID_DRIVE : ipl_pkg::IPL_ID_RELEASE;
        end
      end
      ipl_pkg::IPL_ID_RELEASE: begin
        if (id_phase_end) begin
          next_id_state = I_MODULE_ID_LINE ? ipl_pkg::IPL_ID_DONE : ipl_pkg::IPL_ID_DRIVE;
        end
      end
      default: begin
        next_id_cnt = '0;
      end
    endcase
  end

  // Probe registers; outputs follow the next state so they stay flopped
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      id_state <= ipl_pkg::IPL_ID_DRIVE;
      id_cnt <= '0;
      O_MODULE_DETECTED <= 1'b0;
      O_MODULE_ID_LINE_OE_N <= 1'b1;
      O_MODULE_ID_LINE_VALUE <= 1'b0;
    end else begin
      id_state <= next_id_state;
      id_cnt <= next_id_cnt;
      O_MODULE_DETECTED <= (next_id_state == ipl_pkg::IPL_ID_DONE);
      O_MODULE_ID_LINE_OE_N <= (next_id_state != ipl_pkg::IPL_ID_DRIVE);
      O_MODULE_ID_LINE_VALUE <= 1'b0;
    end
  end

  // Output bundles, all straight from flip-flops
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      O_INJ_STATUS[i] = '{cycle_end_flag: end_flag[i], injector_open_flag: inj_open[i],
                          injector_short_flag: inj_short[i]};
      O_LS_STATUS[i] = '{lowside_open_flag: ls_open[i], lowside_short_flag: ls_short[i]};
    end
  end
  assign O_INJ_DRIVE = inj_active;
  assign O_INJ_PEAK = inj_peak_on;
  assign O_LS_DRIVE = ls_drive;

endmodule : ipl_top

// ==== design/ipl_pkg.sv ====
// Shared constants and bundle types for the injector pulse and low-side PWM block
// Contract
// - Everything runs from one 40 MHz clock
// - No fuel pulses while channel enable false
// - Normal mode fires at programmed start angle
// - Immediate mode fires once per fire-now assertion
// - Cycle-end angle stops pulse and rearms channel
// - Cycle-end flag sets at angle, stays set
// - Cycle-end flag clears on its clear control
// - Peak phase lasts count times 64 ticks
// - Pulse length in clocks, low 24 bits
// - Injector short latches flag, output off
// - Injector fault clear drops flag, re-enables
// - Injector open flag follows the open load
// - Low-side switch open while PWM disabled
// - PWM period in 2 MHz ticks, 20 bits
// - Close at period start, open after on-time
// - Zero on-time keeps switch open
// - On-time at least period keeps switch closed
// - Low-side short latches flag, channel off
// - Low-side fault clear drops short flag
// - Low-side open flag follows the open load
// - Module detected raised after presence check
// - Identification line has enable and data outputs
package ipl_pkg;

  localparam int NCH = 4;
  localparam int CORE_CLK_HZ = 40_000_000;
  localparam int TICK_HZ = 2_000_000;
  localparam int TICK_DIV = CORE_CLK_HZ / TICK_HZ;
  localparam int TICK_CNT_W = 5;
  localparam int PEAK_SCALE = 64;
  localparam int PEAK_W = 8;
  localparam int PEAK_CNT_W = 14;
  localparam int LEN_W = 24;
  localparam int LEN_IN_W = 32;
  localparam int LS_W = 20;
  localparam int LS_IN_W = 32;
  localparam int POS_W = 16;
  // Presence probe phase length
  localparam int ID_PHASE_NS = 10_000;
  localparam int ID_PHASE_CYCLES = ID_PHASE_NS * (CORE_CLK_HZ / 1_000_000) / 1000;
  localparam int ID_CNT_W = 12;

  typedef enum logic [1:0] {
    IPL_ID_DRIVE = 2'b00,
    IPL_ID_RELEASE = 2'b01,
    IPL_ID_DONE = 2'b10
  } ipl_id_state_t;

  typedef struct packed {
    logic sync_valid;
    logic [POS_W-1:0] crank_tick_position;
  } ipl_engine_sync_bundle_t;

  typedef struct packed {
    logic fuel_channel_enable;
    logic fuel_immediate_mode;
    logic fuel_fire_now;
    logic cycle_end_flag_clear;
    logic injector_fault_clear;
    logic [POS_W-1:0] pulse_start_angle;
    logic [POS_W-1:0] cycle_end_angle;
    logic [PEAK_W-1:0] peak_time;
    logic [LEN_IN_W-1:0] pulse_length;
  } ipl_injector_control_group_t;

  typedef struct packed {
    logic lowside_pwm_enable;
    logic lowside_fault_clear;
    logic [LS_IN_W-1:0] lowside_period;
    logic [LS_IN_W-1:0] lowside_on_time;
  } ipl_lowside_control_group_t;

  typedef struct packed {
    logic cycle_end_flag;
    logic injector_open_flag;
    logic injector_short_flag;
  } ipl_injector_status_group_t;

  typedef struct packed {
    logic lowside_open_flag;
    logic lowside_short_flag;
  } ipl_lowside_status_group_t;

endpackage : ipl_pkg

// ==== testbench/ipl_drv_model.sv ====
// Driver circuit model: fault sense and the pulled-up id line
`timescale 1ns/100ps
module ipl_drv_model (
  input wire logic i_oe_n, // Id line enable, low drives
  input wire logic i_val, // Id line data
  input wire logic [3:0] i_drive, // Switch commands
  input wire logic [3:0] i_opn, // Open load to show
  input wire logic [3:0] i_sht, // Short to show
  output logic [3:0] o_open, // Open-load sense
  output logic [3:0] o_short, // Short sense
  output logic o_id // Id line level
);
  // Pull-up wins once the block lets go of the line
  assign o_id = i_oe_n ? 1'b1 : i_val;
  // A short only draws current while the switch is on
  assign o_short = i_sht & i_drive;
  assign o_open = i_opn;
endmodule : ipl_drv_model

// ==== testbench/ipl_props.sv ====
// Concurrent checks on the injector and low-side block ports
`timescale 1ns/100ps
module ipl_props (
  input wire logic I_CORE_CLK, // Core clock
  input wire logic I_SYS_RST, // Sync reset
  input wire ipl_pkg::ipl_engine_sync_bundle_t I_SYNC, // Tracker bundle
  input wire ipl_pkg::ipl_injector_control_group_t [3:0] I_INJ_CTRL, // Injector controls
  input wire ipl_pkg::ipl_lowside_control_group_t [3:0] I_LS_CTRL, // Low-side controls
  input wire logic [3:0] I_INJ_OPEN_SENSE, // Open sense
  input wire logic [3:0] I_INJ_SHORT_SENSE, // Short sense
  input wire logic [3:0] I_LS_SHORT_SENSE, // Low-side short sense
  input wire ipl_pkg::ipl_injector_status_group_t [3:0] O_INJ_STATUS, // Injector flags
  input wire ipl_pkg::ipl_lowside_status_group_t [3:0] O_LS_STATUS, // Low-side flags
  input wire logic [3:0] O_INJ_DRIVE, // Injector command
  input wire logic [3:0] O_LS_DRIVE, // Switch closed
  input wire logic O_MODULE_DETECTED, // Module found
  input wire logic O_MODULE_ID_LINE_OE_N, // Id enable
  input wire logic O_MODULE_ID_LINE_VALUE // Id data
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  ipl_pkg::ipl_injector_control_group_t c0;
  ipl_pkg::ipl_lowside_control_group_t l3;
  logic cend0;
  // Injector channel 0 and low-side channel 3 carry the bench traffic after the angle-mode pass over all four injectors
  assign c0 = I_INJ_CTRL[0];
  assign l3 = I_LS_CTRL[3];
  assign cend0 = I_SYNC.sync_valid && I_SYNC.crank_tick_position == c0.cycle_end_angle;
  inj_off_a: assert property (!c0.fuel_channel_enable |=> !O_INJ_DRIVE[0])
    else $error("injector driven while disabled");
  fire_now_a: assert property (c0.fuel_immediate_mode && c0.fuel_channel_enable
    && c0.fuel_fire_now && !$past(c0.fuel_fire_now) && !O_INJ_STATUS[0].injector_short_flag
    && !I_INJ_SHORT_SENSE[0] && c0.pulse_length[23:0] != 0 && !cend0 |=> O_INJ_DRIVE[0])
    else $error("fire-now rise gave no pulse");
  cycle_end_a: assert property (cend0 |=>
    O_INJ_STATUS[0].cycle_end_flag && !O_INJ_DRIVE[0]) else $error("cycle end missed");
  cend_clear_a: assert property (c0.cycle_end_flag_clear && !cend0 |=>
    !O_INJ_STATUS[0].cycle_end_flag) else $error("cycle-end flag kept");
  inj_short_a: assert property (I_INJ_SHORT_SENSE[0] |=>
    O_INJ_STATUS[0].injector_short_flag && !O_INJ_DRIVE[0]) else $error("short not latched");
  inj_clear_a: assert property (c0.injector_fault_clear && !I_INJ_SHORT_SENSE[0] |=>
    !O_INJ_STATUS[0].injector_short_flag) else $error("short flag kept");
  inj_open_a: assert property (1 |=> O_INJ_STATUS[0].injector_open_flag ==
    $past(I_INJ_OPEN_SENSE[0])) else $error("open flag lags the load");
  ls_off_a: assert property (
    !l3.lowside_pwm_enable || l3.lowside_on_time[19:0] == 0 |=> !O_LS_DRIVE[3])
    else $error("switch closed while off");
  ls_full_a: assert property (l3.lowside_pwm_enable && l3.lowside_on_time[19:0] != 0
    && l3.lowside_on_time[19:0] >= l3.lowside_period[19:0] && !O_LS_STATUS[3].lowside_short_flag
    && !I_LS_SHORT_SENSE[3] |=> O_LS_DRIVE[3]) else $error("full on not closed");
  ls_short_a: assert property (I_LS_SHORT_SENSE[3] |=>
    O_LS_STATUS[3].lowside_short_flag && !O_LS_DRIVE[3]) else $error("low-side short not latched");
  id_data_a: assert property (!O_MODULE_ID_LINE_OE_N |-> !O_MODULE_ID_LINE_VALUE)
    else $error("id line driven high");
  detect_a: assert property ($rose(O_MODULE_DETECTED) |->
    $past(O_MODULE_ID_LINE_OE_N)) else $error("detected outside release phase");
endmodule : ipl_props

// ==== testbench/tb.sv ====
// Self-checking bench for the injector pulse and low-side PWM block
`timescale 1ns/100ps
module tb;
  logic clk = 0;
  logic rst = 1;
  ipl_pkg::ipl_engine_sync_bundle_t sy = '0;
  ipl_pkg::ipl_injector_control_group_t [3:0] ic = '0;
  ipl_pkg::ipl_lowside_control_group_t [3:0] lc = '0;
  logic [3:0] iop = 0, ish = 0, lop = 0, lsh = 0, idr, pk, ldr, ios, iss, los, lss;
  ipl_pkg::ipl_injector_status_group_t [3:0] ist;
  ipl_pkg::ipl_lowside_status_group_t [3:0] lst;
  logic det, oen, val, idl;
  int miscompares = 0, checked = 0, seed = 34775, n, p, pr, on, e, lens[4], q[$];
  ipl_top uut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_SYNC(sy), .I_INJ_CTRL(ic),
    .I_LS_CTRL(lc), .I_INJ_OPEN_SENSE(ios), .I_INJ_SHORT_SENSE(iss), .I_LS_OPEN_SENSE(los),
    .I_LS_SHORT_SENSE(lss), .I_MODULE_ID_LINE(idl), .O_INJ_STATUS(ist), .O_LS_STATUS(lst),
    .O_INJ_DRIVE(idr), .O_INJ_PEAK(pk), .O_LS_DRIVE(ldr), .O_MODULE_DETECTED(det),
    .O_MODULE_ID_LINE_OE_N(oen), .O_MODULE_ID_LINE_VALUE(val));
  ipl_drv_model inj (.i_oe_n(oen), .i_val(val), .i_drive(idr), .i_opn(iop), .i_sht(ish),
    .o_open(ios), .o_short(iss), .o_id(idl));
  ipl_drv_model ls (.i_oe_n(1'b1), .i_val(1'b0), .i_drive(ldr), .i_opn(lop), .i_sht(lsh),
    .o_open(los), .o_short(lss), .o_id());
  // 40 MHz core clock, every cycle count below is in its periods
  initial forever #12.5 clk = ~clk;
  task automatic go(input int k);
    repeat (k) @(posedge clk);
  endtask : go
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", s, exp, seen);
    end
  endtask : chk
  // Wait for a pulse on channel c, then count its length and its peak share
  task automatic pulse(input int c);
    int k;
    k = 0;
    n = 0;
    p = 0;
    // Step off the edge so a drive launched at this very edge is counted
    #1;
    while (idr[c] !== 1'b1 && k < 99) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (idr[c] === 1'b1 && n < 40000) begin
      n++;
      p += pk[c];
      @(posedge clk);
      #1;
    end
  endtask : pulse
  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // Watchdog: the sequence needs at most about 18k cycles
  initial begin
    #(25 * 80000);
    miscompares++;
    finish_test;
  end
  // Main sequence
  initial begin
    go(16);
    rst <= 1'b0;
    go(1);
    #1;
    chk("idle drives", {idr, ldr}, 0);
    // Angle mode per channel; length upper byte must be ignored
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      lens[c] = 1400 + ($random(seed) & 255);
      q.push_back(lens[c]);
      ic[c].fuel_channel_enable <= 1'b1;
      ic[c].pulse_start_angle <= 16'(256 + c);
      ic[c].cycle_end_angle <= 16'h2000;
      ic[c].peak_time <= 8'h01;
      ic[c].pulse_length <= {8'hA5, 24'(lens[c])};
      @(posedge clk);
      sy <= {1'b1, 16'(256 + c)};
      @(posedge clk);
      sy.crank_tick_position <= 16'h0050;
      pulse(c);
      chk("length", n, q.pop_front());
      chk("peak", p >= 1260 && p <= 1300, 1);
    end
    $display("angle mode done");
    // Second start is refused until cycle end rearms; cycle end cuts
    @(posedge clk) sy.crank_tick_position <= 16'h0100;
    go(3);
    #1;
    chk("unarmed", idr[0], 0);
    @(posedge clk) sy.crank_tick_position <= 16'h2000;
    @(posedge clk) sy.crank_tick_position <= 16'h0100;
    @(posedge clk) sy.crank_tick_position <= 16'h0050;
    go(50);
    #1;
    chk("rearmed", {ist[0].cycle_end_flag, idr[0]}, 2'b11);
    @(posedge clk) sy.crank_tick_position <= 16'h2000;
    @(posedge clk);
    sy.crank_tick_position <= 16'h0050;
    ic[0].cycle_end_flag_clear <= 1'b1;
    @(posedge clk) ic[0].cycle_end_flag_clear <= 1'b0;
    #1;
    chk("cut", {ist[0].cycle_end_flag, idr[0]}, 2'b00);
    $display("cycle end done");
    // Immediate mode: one pulse per fire-now rise
    @(posedge clk);
    ic[0].fuel_immediate_mode <= 1'b1;
    ic[0].fuel_fire_now <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      pulse(0);
      chk("imm length", n, lens[0]);
      go(40);
      #1;
      chk("imm once", idr[0], 0);
      @(posedge clk) ic[0].fuel_fire_now <= 1'b0;
      @(posedge clk) ic[0].fuel_fire_now <= 1'b1;
    end
    // Short mid pulse latches off until cleared
    go(50);
    ish[0] <= 1'b1;
    go(2);
    #1;
    chk("short", {ist[0].injector_short_flag, idr[0]}, 2'b10);
    @(posedge clk);
    ish[0] <= 1'b0;
    ic[0].fuel_fire_now <= 1'b0;
    @(posedge clk) ic[0].fuel_fire_now <= 1'b1;
    go(5);
    #1;
    chk("short held", {ist[0].injector_short_flag, idr[0]}, 2'b10);
    @(posedge clk) ic[0].injector_fault_clear <= 1'b1;
    @(posedge clk);
    ic[0].injector_fault_clear <= 1'b0;
    ic[0].fuel_fire_now <= 1'b0;
    @(posedge clk) ic[0].fuel_fire_now <= 1'b1;
    pulse(0);
    chk("refire", n, lens[0]);
    @(posedge clk);
    ic[0].fuel_channel_enable <= 1'b0;
    ic[0].fuel_fire_now <= 1'b0;
    iop[0] <= 1'b1;
    @(posedge clk) ic[0].fuel_fire_now <= 1'b1;
    go(3);
    #1;
    chk("disabled", {ist[0].injector_open_flag, idr[0]}, 2'b10);
    @(posedge clk) iop[0] <= 1'b0;
    go(2);
    #1;
    chk("open gone", ist[0].injector_open_flag, 0);
    $display("immediate and faults done");
    // PWM duty over three whole periods, off, partial and full on
    for (int k = 0; k < 6; k++) begin
      pr = 1 + ($random(seed) & 7);
      on = k == 0 ? 0 : k == 1 ? pr + 3 : 1 + ($random(seed) & 255) % pr;
      e = on >= pr ? 60 * pr : 60 * on;
      @(posedge clk);
      lc[3].lowside_period <= 32'h0010_0000 | pr;
      lc[3].lowside_on_time <= 32'h0030_0000 | on;
      lc[3].lowside_pwm_enable <= 1'b1;
      go(60 * pr);
      #1;
      n = 0;
      repeat (60 * pr) begin
        n += ldr[3];
        @(posedge clk);
        #1;
      end
      chk("duty", n, e);
      @(posedge clk) lc[3].lowside_pwm_enable <= 1'b0;
      go(2);
      #1;
      chk("pwm off", ldr[3], 0);
    end
    // Low-side short and open while fully on; the short only shows while closed
    @(posedge clk);
    lc[3].lowside_pwm_enable <= 1'b1;
    lc[3].lowside_on_time <= 32'h0000_0100;
    go(3);
    lsh[3] <= 1'b1;
    go(2);
    #1;
    chk("ls short", {lst[3].lowside_short_flag, ldr[3]}, 2'b10);
    @(posedge clk);
    lsh[3] <= 1'b0;
    lop[3] <= 1'b1;
    go(4);
    #1;
    chk("ls held", {lst[3], ldr[3]}, 3'b110);
    @(posedge clk);
    lop[3] <= 1'b0;
    lc[3].lowside_fault_clear <= 1'b1;
    @(posedge clk) lc[3].lowside_fault_clear <= 1'b0;
    go(2);
    #1;
    chk("ls clear", {lst[3], ldr[3]}, 3'b001);
    for (int k = 0; k < 3000 && det !== 1'b1; k++) @(posedge clk);
    #1;
    chk("detected", det, 1);
    $display("low-side and presence done");
    finish_test;
  end
endmodule : tb
bind ipl_top ipl_props chk (.I_CORE_CLK, .I_SYS_RST, .I_SYNC, .I_INJ_CTRL, .I_LS_CTRL,
  .I_INJ_OPEN_SENSE, .I_INJ_SHORT_SENSE, .I_LS_SHORT_SENSE, .O_INJ_STATUS, .O_LS_STATUS,
  .O_INJ_DRIVE, .O_LS_DRIVE, .O_MODULE_DETECTED, .O_MODULE_ID_LINE_OE_N,
  .O_MODULE_ID_LINE_VALUE);
